//--- rtl/aqs_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the queued converter sequencer. Included by the package and the top.
`ifndef AQS_DEFINES_SVH
`define AQS_DEFINES_SVH

// Word addresses on the register port
`define AQS_ADDR_W 9
`define AQS_CTRL0_ADDR 9'h000
`define AQS_CTRL1_ADDR 9'h001
`define AQS_CTRL2_ADDR 9'h002
`define AQS_STATUS_ADDR 9'h003
`define AQS_TRIGGER_ADDR 9'h004
`define AQS_POINTER_ADDR 9'h005
`define AQS_TIMER_ADDR 9'h006
// Table regions chosen by address bits 8:6
`define AQS_REG_REGION 3'h0
`define AQS_CCW_REGION 3'h1
`define AQS_RES_RJU_REGION 3'h2
`define AQS_RES_LJS_REGION 3'h3
`define AQS_RES_LJU_REGION 3'h4

// Table sizes and field layout of a command word
`define AQS_ENTRIES 64
`define AQS_RES_W 10
`define AQS_CCW_PAUSE_BIT 6
`define AQS_CCW_ALTREF_BIT 7
// Channel codes
`define AQS_CH_REF_HIGH 6'h3C
`define AQS_CH_REF_LOW 6'h3D
`define AQS_CH_REF_MID 6'h3E
`define AQS_CH_END 6'h3F
`define AQS_CH_XMUX_LIMIT 6'h20
`define AQS_CH_DIRECT_LIMIT 6'h10
`define AQS_CH_XDIRECT_LIMIT 6'h30

// Control field positions
`define AQS_CTRL0_XMUX_BIT 7
`define AQS_CTRL1_IE_LSB 6
// Status bits: complete 1:0, pause 3:2, trigger overrun 5:4
`define AQS_ST_CF_LSB 0
`define AQS_ST_PF_LSB 2
`define AQS_ST_TOR_LSB 4

// Reset values
`define AQS_PRESCALE_RST 7'h00
`define AQS_Q2BEG_RST 6'h20
`define AQS_TIMER_RST 16'hFFFF

// Conversion clock periods spent sampling, and the index of the first trial bit
`define AQS_SAMPLE_TICKS 2'h2
`define AQS_MSB_INDEX 4'h9

`endif

//--- rtl/aqs_pkg.sv
// Types for the queued converter sequencer: states, queue modes, state record.
// Assumes aqs_defines.svh sits on the include path.
`include "aqs_defines.svh"

package aqs_pkg;

    // Converter sequence states
    typedef enum logic [1:0] {
        AQS_IDLE = 2'b00,
        AQS_SAMPLE = 2'b01,
        AQS_CONVERT = 2'b10,
        AQS_STORE = 2'b11
    } aqs_state_type;

    // Queue operating modes
    typedef enum logic [2:0] {
        AQS_MODE_OFF = 3'b000,
        AQS_MODE_SW_SINGLE = 3'b001,
        AQS_MODE_EXT_SINGLE = 3'b010,
        AQS_MODE_TMR_SINGLE = 3'b011,
        AQS_MODE_SW_CONT = 3'b100,
        AQS_MODE_EXT_CONT = 3'b101,
        AQS_MODE_TMR_CONT = 3'b110,
        AQS_MODE_GATED_CONT = 3'b111
    } aqs_mode_type;

    // Whole state of the sequencer
    typedef struct packed {
        aqs_state_type state;
        logic [6:0] pcnt;
        logic tick;
        logic [15:0] tcnt;
        logic ttick;
        logic [63:0][15:0] conversion_command_word;
        logic [63:0][9:0] res;
        logic [6:0] prescale;
        logic xmux;
        logic [1:0][2:0] mode;
        logic [3:0] ie;
        logic [5:0] q2beg;
        logic [15:0] period;
        logic [5:0] status;
        logic [1:0][5:0] ptr;
        logic [1:0] run;
        logic [1:0] done;
        logic [1:0] trig_prev;
        logic cur;
        logic [5:0] chan;
        logic alt;
        logic pause;
        logic [1:0] scnt;
        logic [9:0] approximation_register;
        logic [3:0] bitn;
        logic [15:0] rdata;
    } aqs_state_rec_type;

endpackage : aqs_pkg

//--- rtl/aqs_top.sv
// Queued successive-approximation converter control: queues, pause, triggers,
// prescaler, APPROXIMATION_REGISTER sequencing and the register port.
// Assumes one system clock, a comparator that answers within one
// conversion clock period, and a master that keeps the port protocol.
`timescale 1ns/10ps
`default_nettype none
`include "aqs_defines.svh"

module aqs_top
    import aqs_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [8:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic [1:0] ext_trig_in,
    input wire logic comp_in,
    output logic [15:0] chan_sel_out,
    output logic [1:0] ext_mux_sel_out,
    output logic [2:0] ext_mux_addr_out,
    output logic [1:0] ref_sel_out,
    output logic alt_ref_out,
    output logic sample_out,
    output logic [9:0] dac_code_out,
    output logic conv_clk_out,
    output logic [1:0] irq_complete_out,
    output logic [1:0] irq_pause_out
);

    aqs_state_rec_type s_r;
    aqs_state_rec_type s_nxt;

    //------------------------------------------------------------
    // Combinational helpers
    //------------------------------------------------------------
    logic [6:0] div_eff;
    logic [1:0] sw_trig;
    logic [1:0] trig;
    logic [1:0] cont;
    logic [1:0][5:0] q_start;
    logic [1:0][5:0] q_last;
    logic [15:0] cur_ccw;
    logic [5:0] wr_idx;
    logic [9:0] rd_res;
    logic [5:0] st_set;
    logic [5:0] st_clr;
    logic sel;

    // Zero field still divides by two, so the converter never sees the raw clock
    assign div_eff = (s_r.prescale == 7'h00) ? 7'h01 : s_r.prescale;
    assign sw_trig = (wr_in && addr_in == `AQS_TRIGGER_ADDR) ? wdata_in[1:0] : 2'b00;
    assign q_start[0] = 6'h00;
    assign q_start[1] = s_r.q2beg;
    assign q_last[0] = s_r.q2beg - 6'h01;
    assign q_last[1] = 6'h3F;
    assign wr_idx = addr_in[5:0];
    assign rd_res = s_r.res[addr_in[5:0]];

    // Trigger kind comes only from the queue's own mode
    // Gated mode follows the pin level, not an edge; queue two never holds that
    // code because the control write folds it to off
    always_comb begin
        for (int q = 0; q < 2; q++) begin
            unique case (aqs_mode_type'(s_r.mode[q]))
                AQS_MODE_SW_SINGLE, AQS_MODE_SW_CONT: trig[q] = sw_trig[q];
                AQS_MODE_EXT_SINGLE, AQS_MODE_EXT_CONT: begin
                    trig[q] = ext_trig_in[q] & ~s_r.trig_prev[q];
                end
                AQS_MODE_TMR_SINGLE, AQS_MODE_TMR_CONT: trig[q] = s_r.ttick;
                AQS_MODE_GATED_CONT: trig[q] = (q == 0) && ext_trig_in[0] && !s_r.run[0];
                AQS_MODE_OFF: trig[q] = 1'b0;
            endcase
            cont[q] = s_r.mode[q][2];
        end
    end

    //------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        st_set = 6'h00;
        st_clr = 6'h00;
        sel = s_r.run[0] ? 1'b0 : 1'b1;
        cur_ccw = s_r.conversion_command_word[s_r.ptr[sel]];

        // Conversion clock prescaler
        s_nxt.tick = (s_r.pcnt == div_eff);
        s_nxt.pcnt = (s_r.pcnt >= div_eff) ? 7'h00 : s_r.pcnt + 7'h01;

        // Periodic timer for timer-triggered modes
        s_nxt.ttick = (s_r.tcnt == s_r.period);
        s_nxt.tcnt = (s_r.tcnt >= s_r.period) ? 16'h0000 : s_r.tcnt + 16'h0001;

        s_nxt.trig_prev = ext_trig_in;

        // Trigger acceptance; busy queues only record overrun
        // A running sub-queue is never restarted, so the event only sets the overrun flag
        for (int q = 0; q < 2; q++) begin
            if (trig[q] && !s_r.done[q]) begin
                if (s_r.run[q]) begin
                    st_set[`AQS_ST_TOR_LSB + q] = 1'b1;
                end else begin
                    s_nxt.run[q] = 1'b1;
                end
            end
        end

        // Register writes
        if (wr_in) begin
            if (addr_in == `AQS_CTRL0_ADDR) begin
                s_nxt.prescale = wdata_in[6:0];
                s_nxt.xmux = wdata_in[`AQS_CTRL0_XMUX_BIT];
            end
            if (addr_in == `AQS_CTRL1_ADDR) begin
                s_nxt.mode[0] = wdata_in[2:0];
                s_nxt.mode[1] = (wdata_in[5:3] == 3'h7) ? 3'h0 : wdata_in[5:3];
                s_nxt.ie = wdata_in[9:6];
                // New mode stops both queues and sets them back to their first word, except that a conversion in flight still stores and steps its queue's pointer
                s_nxt.run = 2'b00;
                s_nxt.done = 2'b00;
                s_nxt.ptr[0] = q_start[0];
                s_nxt.ptr[1] = q_start[1];
            end
            if (addr_in == `AQS_CTRL2_ADDR) s_nxt.q2beg = wdata_in[5:0];
            if (addr_in == `AQS_STATUS_ADDR) st_clr = wdata_in[5:0];
            if (addr_in == `AQS_TIMER_ADDR) s_nxt.period = wdata_in;
            if (addr_in[8:6] == `AQS_CCW_REGION) s_nxt.conversion_command_word[wr_idx] = wdata_in;
        end

        // Converter sequence
        unique case (s_r.state)
            AQS_IDLE: begin
                if (s_r.run[0] && s_r.mode[0] == AQS_MODE_GATED_CONT && !ext_trig_in[0]) begin
                    s_nxt.run[0] = 1'b0;
                    s_nxt.ptr[0] = q_start[0];
                end else if (s_r.run != 2'b00) begin
                    if (cur_ccw[5:0] == `AQS_CH_END ||
                        (!sel && s_r.ptr[0] >= s_r.q2beg)) begin
                        st_set[`AQS_ST_CF_LSB + sel] = 1'b1;
                        s_nxt.run[sel] = 1'b0;
                        s_nxt.ptr[sel] = q_start[sel];
                        s_nxt.done[sel] = ~cont[sel];
                    end else begin
                        s_nxt.cur = sel;
                        s_nxt.chan = cur_ccw[5:0];
                        s_nxt.alt = cur_ccw[`AQS_CCW_ALTREF_BIT];
                        s_nxt.pause = cur_ccw[`AQS_CCW_PAUSE_BIT];
                        s_nxt.scnt = 2'h0;
                        s_nxt.state = AQS_SAMPLE;
                    end
                end
            end
            AQS_SAMPLE: begin
                if (s_r.tick) begin
                    s_nxt.scnt = s_r.scnt + 2'h1;
                    if (s_r.scnt == `AQS_SAMPLE_TICKS - 2'h1) begin
                        s_nxt.approximation_register = 10'h200;
                        s_nxt.bitn = `AQS_MSB_INDEX;
                        s_nxt.state = AQS_CONVERT;
                    end
                end
            end
            AQS_CONVERT: begin
                // Keep or drop the trial bit, then try the next lower one
                if (s_r.tick) begin
                    s_nxt.approximation_register[s_r.bitn] = comp_in;
                    if (s_r.bitn == 4'h0) begin
                        s_nxt.state = AQS_STORE;
                    end else begin
                        s_nxt.approximation_register[s_r.bitn - 4'h1] = 1'b1;
                        s_nxt.bitn = s_r.bitn - 4'h1;
                    end
                end
            end
            AQS_STORE: begin
                s_nxt.res[s_r.ptr[s_r.cur]] = s_r.approximation_register;
                s_nxt.state = AQS_IDLE;
                if (s_r.ptr[s_r.cur] == q_last[s_r.cur]) begin
                    st_set[`AQS_ST_CF_LSB + s_r.cur] = 1'b1;
                    s_nxt.run[s_r.cur] = 1'b0;
                    s_nxt.ptr[s_r.cur] = q_start[s_r.cur];
                    s_nxt.done[s_r.cur] = ~cont[s_r.cur];
                end else begin
                    // Pointer only moves forward until the queue completes
                    s_nxt.ptr[s_r.cur] = s_r.ptr[s_r.cur] + 6'h01;
                    if (s_r.pause) begin
                        s_nxt.run[s_r.cur] = 1'b0;
                        st_set[`AQS_ST_PF_LSB + s_r.cur] = 1'b1;
                    end
                end
            end
        endcase

        // A hardware set in the clearing cycle survives
        s_nxt.status = (s_r.status & ~st_clr) | st_set;

        // Register reads, answered one cycle later
        s_nxt.rdata = 16'h0000;
        if (rd_in) begin
            unique case (addr_in[8:6])
                `AQS_REG_REGION: begin
                    unique case (addr_in)
                        `AQS_CTRL0_ADDR: s_nxt.rdata = {8'h00, s_r.xmux, s_r.prescale};
                        `AQS_CTRL1_ADDR: s_nxt.rdata = {6'h00, s_r.ie, s_r.mode[1], s_r.mode[0]};
                        `AQS_CTRL2_ADDR: s_nxt.rdata = {10'h000, s_r.q2beg};
                        `AQS_STATUS_ADDR: s_nxt.rdata = {10'h000, s_r.status};
                        `AQS_POINTER_ADDR: begin
                            s_nxt.rdata = {2'h0, s_r.ptr[1], 2'h0, s_r.ptr[0]};
                        end
                        `AQS_TIMER_ADDR: s_nxt.rdata = s_r.period;
                        default: s_nxt.rdata = 16'h0000;
                    endcase
                end
                `AQS_CCW_REGION: s_nxt.rdata = s_r.conversion_command_word[addr_in[5:0]];
                `AQS_RES_RJU_REGION: s_nxt.rdata = {6'h00, rd_res};
                `AQS_RES_LJS_REGION: s_nxt.rdata = {~rd_res[9], rd_res[8:0], 6'h00};
                `AQS_RES_LJU_REGION: s_nxt.rdata = {rd_res, 6'h00};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    // Non-zero defaults are loaded over the cleared record
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '0;
            s_r.prescale <= `AQS_PRESCALE_RST;
            s_r.q2beg <= `AQS_Q2BEG_RST;
            s_r.period <= `AQS_TIMER_RST;
            s_r.state <= AQS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    //------------------------------------------------------------
    // Analog side decode
    //------------------------------------------------------------
    // Only the active conversion drives a select; idle leaves every switch open
    always_comb begin
        chan_sel_out = 16'h0000;
        ext_mux_sel_out = 2'h0;
        ext_mux_addr_out = 3'h0;
        ref_sel_out = 2'h0;
        if (s_r.state == AQS_SAMPLE || s_r.state == AQS_CONVERT) begin
            if (s_r.chan == `AQS_CH_REF_HIGH) ref_sel_out = 2'h1;
            else if (s_r.chan == `AQS_CH_REF_LOW) ref_sel_out = 2'h2;
            else if (s_r.chan == `AQS_CH_REF_MID) ref_sel_out = 2'h3;
            else if (s_r.xmux && s_r.chan < `AQS_CH_XMUX_LIMIT) begin
                // Four external muxes of eight feed inputs zero to three
                chan_sel_out[s_r.chan[4:3]] = 1'b1;
                ext_mux_sel_out = s_r.chan[4:3];
                ext_mux_addr_out = s_r.chan[2:0];
            end else if (s_r.xmux && s_r.chan < `AQS_CH_XDIRECT_LIMIT) begin
                chan_sel_out[s_r.chan[3:0]] = 1'b1;
            end else if (!s_r.xmux && s_r.chan < `AQS_CH_DIRECT_LIMIT) begin
                chan_sel_out[s_r.chan[3:0]] = 1'b1;
            end
        end
    end

    assign alt_ref_out = s_r.alt;
    assign sample_out = (s_r.state == AQS_SAMPLE);
    assign dac_code_out = s_r.approximation_register;
    assign conv_clk_out = s_r.tick;
    assign rdata_out = s_r.rdata;
    // Requests are plain levels: flag and enable, cleared through the status word
    assign irq_complete_out = s_r.status[1:0] & {s_r.ie[2], s_r.ie[0]};
    assign irq_pause_out = s_r.status[3:2] & {s_r.ie[3], s_r.ie[1]};

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    a_tick_spacing: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in) s_r.tick |=> !s_r.tick)
        else $error("conversion clock faster than half system clock");

    // A divider rewrite drops the attempt; the old ratio no longer applies
    a_tick_ratio: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in || s_r.prescale != 7'h03)
        (s_r.tick && $stable(s_r.prescale) && s_r.prescale == 7'h03)
        |=> !s_r.tick [*3] ##1 s_r.tick)
        else $error("conversion clock not system clock over field plus one");

    a_one_channel: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in) $onehot0(chan_sel_out))
        else $error("more than one analog input selected");

    a_msb_first: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.state == AQS_SAMPLE && s_nxt.state == AQS_CONVERT)
        |=> s_r.approximation_register == 10'h200 && s_r.bitn == 4'h9)
        else $error("approximation does not begin at the top bit");

    a_overrun_flag: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.run[0] && trig[0] && !s_r.done[0]) |=> s_r.status[`AQS_ST_TOR_LSB])
        else $error("trigger during execution did not set overrun");

    a_pause_entry: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.state == AQS_STORE && s_r.pause && s_r.cur == 1'b0 && s_r.ptr[0] != q_last[0])
        |=> !s_r.run[0] && s_r.status[`AQS_ST_PF_LSB])
        else $error("sub-queue end did not pause queue one");

    a_resume_next: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.state == AQS_STORE && s_r.cur == 1'b1 && s_r.ptr[1] != 6'h3F && !wr_in)
        |=> s_r.ptr[1] == $past(s_r.ptr[1]) + 6'h01)
        else $error("pointer did not move to the following word");

    a_q2_no_gate: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in) s_r.mode[1] != 3'h7)
        else $error("gated mode accepted on queue two");

    a_off_no_start: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.mode[0] == 3'h0 && !s_r.run[0] && !wr_in) |=> !s_r.run[0])
        else $error("disabled queue one started");

    a_done_holds: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.done[0] && !s_r.run[0] && !wr_in) |=> !s_r.run[0])
        else $error("finished single scan queue one started again");

    a_idle_open: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.state == AQS_IDLE || s_r.state == AQS_STORE)
        |-> chan_sel_out == 16'h0000 && ref_sel_out == 2'h0)
        else $error("analog switch closed outside a conversion");

    a_ref_exclusive: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (ref_sel_out != 2'h0) |-> chan_sel_out == 16'h0000)
        else $error("reference and input routed together");

    a_alt_follows: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (s_r.state == AQS_IDLE && s_nxt.state == AQS_SAMPLE)
        |=> alt_ref_out == $past(cur_ccw[`AQS_CCW_ALTREF_BIT]))
        else $error("alternate reference not taken from the command word");

endmodule : aqs_top
`default_nettype wire

//--- verification/aqs_comp_model.sv
// Behavioural analog side: multiplexer, reference levels and comparator.
// Assumes the selects and the trial code come straight from the sequencer.
`timescale 1ns/10ps
`default_nettype none

module aqs_comp_model (
    input wire logic clk_sys_in,
    input wire logic [15:0] chan_sel_in,
    input wire logic [1:0] ref_sel_in,
    input wire logic [9:0] dac_code_in,
    output logic comp_out
);
    logic toggle_r;
    logic [10:0] vin;

    // Nothing selected: output wanders so a stale decision is never reused
    always_ff @(posedge clk_sys_in) begin
        toggle_r <= ~toggle_r;
    end

    // Input level per channel; input i sits at i*60+7
    always_comb begin
        vin = 11'h400;
        case (ref_sel_in)
            2'h1: vin = 11'h3FF;
            2'h2: vin = 11'h000;
            2'h3: vin = 11'h200;
            default: vin = 11'h400;
        endcase
        for (int i = 0; i < 16; i++) begin
            if (chan_sel_in[i]) begin
                vin = 11'(i * 60 + 7);
            end
        end
        comp_out = vin[10] ? toggle_r : (vin[9:0] >= dac_code_in);
    end

    initial toggle_r = 1'b0;
endmodule : aqs_comp_model

`default_nettype wire

//--- verification/adc_queue_sequencer_tb.sv
// Self-checking bench for the queued converter sequencer.
// Assumes the comparator model beside it and the package constants.
`timescale 1ns/10ps
`default_nettype none
`include "aqs_defines.svh"

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module adc_queue_sequencer_tb;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [8:0] addr_in = 9'h000;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [1:0] ext_trig_in = 2'h0;
    logic [15:0] rdata_out, chan_sel_out;
    logic [1:0] ext_mux_sel_out, ref_sel_out, irq_complete_out, irq_pause_out;
    logic [2:0] ext_mux_addr_out;
    logic alt_ref_out, sample_out, conv_clk_out, comp_in;
    logic [9:0] dac_code_out;
    logic [15:0] rv;
    int failures = 0;
    int checks_done = 0;
    int n;
    logic [5:0] mux_seen = 6'h00;

    aqs_top dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ext_trig_in(ext_trig_in), .comp_in(comp_in), .chan_sel_out(chan_sel_out),
        .ext_mux_sel_out(ext_mux_sel_out), .ext_mux_addr_out(ext_mux_addr_out),
        .ref_sel_out(ref_sel_out), .alt_ref_out(alt_ref_out), .sample_out(sample_out),
        .dac_code_out(dac_code_out), .conv_clk_out(conv_clk_out),
        .irq_complete_out(irq_complete_out), .irq_pause_out(irq_pause_out));

    aqs_comp_model analog (.clk_sys_in(clk_sys_in), .chan_sel_in(chan_sel_out),
        .ref_sel_in(ref_sel_out), .dac_code_in(dac_code_out), .comp_out(comp_in));

    // 10 MHz system clock
    always #50 clk_sys_in = ~clk_sys_in;

    // ----------------------------------------
    // Register port tasks
    // ----------------------------------------
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        @(negedge clk_sys_in);
        d = rdata_out;
    endtask : rd

    task automatic rdchk(input logic [8:0] a, input logic [15:0] ex);
        rd(a, rv);
        `CHK("register", ex, rv)
    endtask : rdchk

    // Bounded wait for a request of queue q; pause when cmpl is 0
    task automatic wait_irq(input bit cmpl, input bit q = 1'b0);
        for (n = 0; n < 3000; n++) begin
            @(posedge clk_sys_in);
            if ((cmpl ? irq_complete_out[q] : irq_pause_out[q]) === 1'b1) break;
        end
        `CHK("request wait", 1, int'(n < 3000))
    endtask : wait_irq

    // Cycles between two conversion clock ticks
    task automatic tick_gap(input logic [6:0] pre, input int ex);
        wr(`AQS_CTRL0_ADDR, {9'h000, pre});
        repeat (300) @(posedge clk_sys_in);
        @(posedge conv_clk_out);
        // Count on falling edges, where the tick has settled
        @(negedge clk_sys_in);
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
        end while (conv_clk_out !== 1'b1 && n < 400);
        `CHK("tick period", ex, n)
    endtask : tick_gap

    task automatic finish_test;
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // Exactly one input routed whenever any is
    always @(negedge clk_sys_in) begin
        if (rstn_in && chan_sel_out !== 16'h0000) begin
            `CHK("one-hot select", 1, $countones(chan_sel_out))
        end
    end

    // Mux selects seen while an alternate-reference word samples
    always @(negedge clk_sys_in) begin
        if (sample_out === 1'b1 && alt_ref_out === 1'b1) begin
            mux_seen <= {1'b1, ext_mux_sel_out, ext_mux_addr_out};
        end
    end

    // Hang guard, well beyond the expected run
    initial begin
        #(100 * 60000);
        failures++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rdchk(`AQS_CTRL0_ADDR, 16'h0000);
        rdchk(`AQS_CTRL2_ADDR, 16'h0020);
        rdchk(`AQS_TIMER_ADDR, 16'hFFFF);
        rdchk(9'h007, 16'h0000);
        tick_gap(7'h00, 2);
        tick_gap(7'h03, 4);
        tick_gap(7'h7F, 128);
        wr(`AQS_CTRL0_ADDR, 16'h0000);
        // Two sub-queues: input 3, ref high | midpoint, ref low (alt), end
        wr(9'h040, 16'h0003);
        wr(9'h041, 16'h007C);
        wr(9'h042, 16'h003E);
        wr(9'h043, 16'h00BD);
        wr(9'h044, 16'h003F);
        wr(`AQS_CTRL1_ADDR, 16'h00C1);
        wr(`AQS_TRIGGER_ADDR, 16'h0001);
        repeat (5) @(posedge clk_sys_in);
        wr(`AQS_TRIGGER_ADDR, 16'h0001);
        wait_irq(0);
        rdchk(`AQS_STATUS_ADDR, 16'h0014);
        rd(`AQS_POINTER_ADDR, rv);
        `CHK("pointer", 6'h02, rv[5:0])
        rdchk(9'h080, 16'h00BB);
        rdchk(9'h081, 16'h03FF);
        rdchk(9'h0C0, 16'hAEC0);
        rdchk(9'h100, 16'h2EC0);
        rdchk(9'h082, 16'h0000);
        wr(`AQS_STATUS_ADDR, 16'h003F);
        rdchk(`AQS_STATUS_ADDR, 16'h0000);
        wr(`AQS_TRIGGER_ADDR, 16'h0001);
        wait_irq(1);
        `CHK("alt ref", 6'h20, mux_seen)
        rdchk(9'h082, 16'h0200);
        rdchk(9'h083, 16'h0000);
        rdchk(`AQS_STATUS_ADDR, 16'h0001);
        // Single scan done: a new trigger starts nothing
        wr(`AQS_TRIGGER_ADDR, 16'h0001);
        repeat (100) @(posedge clk_sys_in);
        `CHK("sample idle", 1'b0, sample_out)
        // External rising continuous: each sub-queue needs a new edge
        wr(`AQS_STATUS_ADDR, 16'h003F);
        wr(`AQS_CTRL1_ADDR, 16'h00C5);
        ext_trig_in <= 2'h1;
        wait_irq(0);
        wr(`AQS_STATUS_ADDR, 16'h003F);
        repeat (300) @(posedge clk_sys_in);
        rd(`AQS_POINTER_ADDR, rv);
        `CHK("pointer held", 6'h02, rv[5:0])
        `CHK("pause clear", 1'b0, irq_pause_out[0])
        ext_trig_in <= 2'h0;
        repeat (3) @(posedge clk_sys_in);
        ext_trig_in <= 2'h1;
        wait_irq(1);
        ext_trig_in <= 2'h0;
        // Every mode code; gated is queue one only
        for (int m = 0; m < 8; m++) begin
            wr(`AQS_CTRL1_ADDR, 16'(m * 9));
            rd(`AQS_CTRL1_ADDR, rv);
            `CHK("mode", 6'((m == 7 ? 0 : m * 8) + m), rv[5:0])
        end
        // Queue two on the timer, external muxes on, alternate ref on its first word
        wr(9'h060, 16'h008A);
        wr(9'h061, 16'h0025);
        wr(9'h062, 16'h003F);
        wr(`AQS_CTRL0_ADDR, 16'h0080);
        wr(`AQS_STATUS_ADDR, 16'h003F);
        wr(`AQS_TIMER_ADDR, 16'h0005);
        wr(`AQS_CTRL1_ADDR, 16'h0118);
        wait_irq(1, 1'b1);
        `CHK("mux select", 6'h2A, mux_seen)
        rdchk(9'h0A0, 16'h0043);
        rdchk(9'h0A1, 16'h0133);
        rdchk(`AQS_STATUS_ADDR, 16'h0022);
        rd(`AQS_POINTER_ADDR, rv);
        `CHK("pointer two", 6'h20, rv[13:8])
        // Gated queue one runs while the gate is high and stops at a word boundary
        wr(`AQS_STATUS_ADDR, 16'h003F);
        wr(`AQS_CTRL1_ADDR, 16'h0047);
        ext_trig_in <= 2'h1;
        wait_irq(1);
        ext_trig_in <= 2'h0;
        repeat (100) @(posedge clk_sys_in);
        `CHK("gate stop", 1'b0, sample_out)
        rd(`AQS_POINTER_ADDR, rv);
        `CHK("gate pointer", 6'h00, rv[5:0])
        wr(`AQS_CTRL1_ADDR, 16'h0000);
        finish_test();
    end
endmodule : adc_queue_sequencer_tb

`default_nettype wire
